// ==== src/spgr_pkg.sv ====
// constants for the sensor power, reset and gain register bank
package spgr_pkg;
  localparam int unsigned        ADDR_W          = 8;
  localparam int unsigned        DATA_W          = 8;
  localparam int unsigned        GAIN_W          = 6;
  // register offsets
  localparam logic [7:0]         PWR_CFG_OFS     = 8'h0C;
  localparam logic [7:0]         RST_CTL_OFS     = 8'h0E;
  localparam logic [7:0]         GAIN_A_OFS      = 8'h10;
  // power configuration fields
  localparam int unsigned        PWR_EXT_BIAS_BIT = 3;
  localparam int unsigned        PWR_STANDBY_BIT  = 0;
  localparam logic [7:0]         PWR_CFG_RST      = 8'h00;
  // reset control fields
  localparam int unsigned        RST_FRONT_BIT   = 4;
  localparam int unsigned        RST_POST_BIT    = 3;
  localparam int unsigned        RST_PORT_BIT    = 2;
  localparam int unsigned        RST_STATE_BIT   = 1;
  localparam int unsigned        RST_SOFT_BIT    = 0;
  localparam logic [4:0]         RST_CTL_RST     = 5'h00;
  // exposure gain a and gain b
  localparam logic [5:0]         GAIN_A_RST      = 6'h0E;
  localparam logic [5:0]         GAIN_B_RST      = 6'h0E;
  // gain mode codes as presented by the gain mode register
  typedef enum logic [1:0] {
    SPGR_MODE_RAW  = 2'b00,
    SPGR_MODE_LINEAR_ONE_GAIN_MODE = 2'b01,
    SPGR_MODE_COMBINED_LINEAR_GAIN_MODE = 2'b10
  } spgr_mode_type;
endpackage

// ==== src/spgr_regs.sv ====
// power configuration, reset control and exposure gain a registers
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RQ1 - power bit 3 selects external bias resistor when 1, internal when 0; reset 0.
// RQ2 - power bit 0 written 1 enters soft standby; 0 leaves it; reset 0.
// RQ3 - register port keeps accepting writes to every register during standby.
// RQ4 - leaving standby keeps all registers; first frame afterwards uses them.
// RQ5 - front, post, port or state reset bits return internal state to initial values.
// RQ6 - partial resets leave all user programmable registers untouched.
// RQ7 - reset bit 3 resets non-programmable post converter registers while set.
// RQ8 - reset bit 1 resets state machines and internal registers, keeps programmed values.
// RQ9 - reset bit 0 returns every register, internal and programmable, to default; code spares reset control and the read data register.
// RQ10 - host writes zero to reset control to leave reset; bits never self clear.
// RQ11 - gain a holds six bit code in bits 5..0, reset 001110; bits 7..6 unused.
// RQ12 - gain range of gain a code depends on the gain mode register.
// RQ13 - raw or linear-one mode: gain a and gain b drive two separate stages.
// RQ14 - combined linear mode: gain a code programs both stages as one stage.
// RQ15 - host raises gain b only after gain a reached its maximum code.
// RQ16 - combined linear mode steps average 0.11119 gain; single steps may deviate.
// RQ17 - host writes factory and unused bits as zero, ignores their read-back.
module spgr_regs (
  input  wire logic                          CLK_I,
  input  wire logic                          RST_N_I,
  input  wire logic [spgr_pkg::ADDR_W-1:0]   REG_ADDR_I,
  input  wire logic [spgr_pkg::DATA_W-1:0]   REG_WDATA_I,
  input  wire logic                          REG_WR_I,
  input  wire logic                          REG_RD_I,
  output logic      [spgr_pkg::DATA_W-1:0]   REG_RDATA_O,
  input  wire logic [1:0]                    GAIN_MODE_I,
  input  wire logic [spgr_pkg::GAIN_W-1:0]   GAIN_B_CODE_I,
  input  wire logic                          FRAME_START_I,
  output logic                               EXT_BIAS_SEL_O,
  output logic                               STANDBY_O,
  output logic                               FRONT_CONV_RST_O,
  output logic                               POST_CONV_RST_O,
  output logic                               SENSOR_PORT_RST_O,
  output logic                               STATE_RST_O,
  output logic                               SOFT_RST_O,
  output logic                               INTERNAL_RST_O,
  output logic      [spgr_pkg::GAIN_W-1:0]   STAGE_A_CODE_O,
  output logic      [spgr_pkg::GAIN_W-1:0]   STAGE_B_CODE_O
);

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  logic       ext_bias_r;
  logic       ext_bias_nxt;
  logic       standby_r;
  logic       standby_nxt;
  logic [4:0] rst_ctl_r;
  logic [4:0] rst_ctl_nxt;
  logic [5:0] gain_a_r;
  logic [5:0] gain_a_nxt;
  logic [5:0] stage_a_r;
  logic [5:0] stage_a_nxt;
  logic [5:0] stage_b_r;
  logic [5:0] stage_b_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       wr_pwr;
  logic       wr_rst;
  logic       wr_gain;
  logic       soft_rst;
  logic       partial_rst;
  spgr_pkg::spgr_mode_type mode;

  assign mode        = spgr_pkg::spgr_mode_type'(GAIN_MODE_I);
  assign wr_pwr      = REG_WR_I && hit(REG_ADDR_I, spgr_pkg::PWR_CFG_OFS);
  assign wr_rst      = REG_WR_I && hit(REG_ADDR_I, spgr_pkg::RST_CTL_OFS);
  assign wr_gain     = REG_WR_I && hit(REG_ADDR_I, spgr_pkg::GAIN_A_OFS);
  assign soft_rst    = rst_ctl_r[spgr_pkg::RST_SOFT_BIT];
  assign partial_rst = |rst_ctl_r[spgr_pkg::RST_FRONT_BIT:spgr_pkg::RST_STATE_BIT];

  // user programmable registers; writes stay open in standby
  always_comb begin
    ext_bias_nxt = ext_bias_r;
    standby_nxt  = standby_r;
    rst_ctl_nxt  = rst_ctl_r;
    gain_a_nxt   = gain_a_r;
    if (wr_pwr) begin // RQ3
      ext_bias_nxt = REG_WDATA_I[spgr_pkg::PWR_EXT_BIAS_BIT]; // RQ1
      standby_nxt  = REG_WDATA_I[spgr_pkg::PWR_STANDBY_BIT]; // RQ2
    end
    if (wr_gain) begin
      gain_a_nxt = REG_WDATA_I[5:0]; // RQ11
    end
    // bits are held until the host writes them back; never self clearing
    if (wr_rst) begin // RQ10
      rst_ctl_nxt = REG_WDATA_I[4:0];
    end
    // soft reset forces defaults but spares reset control, else it would self clear
    if (soft_rst) begin // RQ9 RQ6
      ext_bias_nxt = spgr_pkg::PWR_CFG_RST[spgr_pkg::PWR_EXT_BIAS_BIT];
      standby_nxt  = spgr_pkg::PWR_CFG_RST[spgr_pkg::PWR_STANDBY_BIT];
      gain_a_nxt   = spgr_pkg::GAIN_A_RST;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ext_bias_r <= spgr_pkg::PWR_CFG_RST[spgr_pkg::PWR_EXT_BIAS_BIT];
      standby_r  <= spgr_pkg::PWR_CFG_RST[spgr_pkg::PWR_STANDBY_BIT];
      rst_ctl_r  <= spgr_pkg::RST_CTL_RST;
      gain_a_r   <= spgr_pkg::GAIN_A_RST;
    end else begin
      ext_bias_r <= ext_bias_nxt;
      standby_r  <= standby_nxt;
      rst_ctl_r  <= rst_ctl_nxt;
      gain_a_r   <= gain_a_nxt;
    end
  end

  // internal stage codes, loaded from gain only at frame start (internal resets force defaults) so a frame never sees a half update
  always_comb begin
    stage_a_nxt = stage_a_r;
    stage_b_nxt = stage_b_r;
    if (partial_rst || soft_rst) begin // RQ5 RQ7 RQ8
      stage_a_nxt = spgr_pkg::GAIN_A_RST;
      stage_b_nxt = spgr_pkg::GAIN_B_RST;
    end else if (FRAME_START_I && !standby_r) begin // RQ4
      unique case (mode) // RQ12
        spgr_pkg::SPGR_MODE_RAW,
        spgr_pkg::SPGR_MODE_LINEAR_ONE_GAIN_MODE: begin
          stage_a_nxt = gain_a_r; // RQ13
          stage_b_nxt = GAIN_B_CODE_I;
        end
        spgr_pkg::SPGR_MODE_COMBINED_LINEAR_GAIN_MODE: begin
          // one code drives both stages; step size averages out, not uniform
          stage_a_nxt = gain_a_r; // RQ14 RQ16
          stage_b_nxt = gain_a_r;
        end
        // code 11 is the no-update code from the mode register; stages keep their value
        default: begin
          stage_a_nxt = stage_a_r;
          stage_b_nxt = stage_b_r;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      stage_a_r <= spgr_pkg::GAIN_A_RST;
      stage_b_r <= spgr_pkg::GAIN_B_RST;
    end else begin
      stage_a_r <= stage_a_nxt;
      stage_b_r <= stage_b_nxt;
    end
  end

  // read-back; factory and unused bits read as zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (REG_RD_I) begin
      rdata_nxt = 8'h00;
      if (hit(REG_ADDR_I, spgr_pkg::PWR_CFG_OFS)) begin
        rdata_nxt[spgr_pkg::PWR_EXT_BIAS_BIT] = ext_bias_r;
        rdata_nxt[spgr_pkg::PWR_STANDBY_BIT]  = standby_r;
      end else if (hit(REG_ADDR_I, spgr_pkg::RST_CTL_OFS)) begin
        rdata_nxt[4:0] = rst_ctl_r;
      end else if (hit(REG_ADDR_I, spgr_pkg::GAIN_A_OFS)) begin
        rdata_nxt[5:0] = gain_a_r; // RQ11
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign REG_RDATA_O       = rdata_r;
  assign EXT_BIAS_SEL_O    = ext_bias_r;
  assign STANDBY_O         = standby_r;
  assign FRONT_CONV_RST_O  = rst_ctl_r[spgr_pkg::RST_FRONT_BIT];
  assign POST_CONV_RST_O   = rst_ctl_r[spgr_pkg::RST_POST_BIT];
  assign SENSOR_PORT_RST_O = rst_ctl_r[spgr_pkg::RST_PORT_BIT];
  assign STATE_RST_O       = rst_ctl_r[spgr_pkg::RST_STATE_BIT];
  assign SOFT_RST_O        = soft_rst;
  assign INTERNAL_RST_O    = partial_rst || soft_rst; // RQ5
  assign STAGE_A_CODE_O    = stage_a_r;
  assign STAGE_B_CODE_O    = stage_b_r;

  // checks
  sequence s_pwr_write;
    wr_pwr && !soft_rst;
  endsequence

  sequence s_frame_apply;
    FRAME_START_I && !standby_r && !partial_rst && !soft_rst;
  endsequence

  sequence s_frame_split;
    s_frame_apply ##0 (mode == spgr_pkg::SPGR_MODE_RAW || mode == spgr_pkg::SPGR_MODE_LINEAR_ONE_GAIN_MODE);
  endsequence

  sequence s_frame_keep;
    s_frame_apply ##0 (GAIN_MODE_I == 2'h3);
  endsequence

  a_bias_select_write: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ1
    s_pwr_write |=> EXT_BIAS_SEL_O == $past(REG_WDATA_I[3]))
    else $error("bias select does not follow power write");

  a_standby_enter_leave: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ2
    s_pwr_write |=> STANDBY_O == $past(REG_WDATA_I[0]))
    else $error("standby does not follow power write");

  a_standby_gain_write: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ3
    STANDBY_O && wr_gain && !soft_rst |=> gain_a_r == $past(REG_WDATA_I[5:0]))
    else $error("gain write lost during standby");

  a_frame_apply_gain: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ4
    s_frame_apply ##0 !wr_gain ##0 (GAIN_MODE_I != 2'h3) |=> STAGE_A_CODE_O == gain_a_r)
    else $error("frame start did not apply gain a");

  a_standby_holds_stage: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ4
    STANDBY_O && !INTERNAL_RST_O |=> $stable(STAGE_A_CODE_O) && $stable(STAGE_B_CODE_O))
    else $error("stage codes moved in standby");

  a_internal_rst_stage: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ5
    INTERNAL_RST_O |=> STAGE_A_CODE_O == spgr_pkg::GAIN_A_RST && STAGE_B_CODE_O == spgr_pkg::GAIN_B_RST)
    else $error("internal state not reset");

  a_partial_keeps_user: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ6
    partial_rst && !soft_rst && !REG_WR_I |=> $stable(gain_a_r) && $stable(ext_bias_r) && $stable(standby_r))
    else $error("partial reset changed user register");

  a_post_rst_level: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ7
    wr_rst && REG_WDATA_I[3] ##1 !wr_rst [*2] |-> POST_CONV_RST_O && INTERNAL_RST_O)
    else $error("post converter reset not held");

  a_soft_rst_defaults: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ9
    SOFT_RST_O |=> gain_a_r == spgr_pkg::GAIN_A_RST && !EXT_BIAS_SEL_O && !STANDBY_O)
    else $error("soft reset did not restore defaults");

  a_rst_ctl_held: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ10
    rst_ctl_r != 5'h00 && !wr_rst |=> $stable(rst_ctl_r))
    else $error("reset control cleared itself");

  a_gain_readback: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ11
    REG_RD_I && hit(REG_ADDR_I, spgr_pkg::GAIN_A_OFS) |=> REG_RDATA_O == {2'b00, $past(gain_a_r)})
    else $error("gain a read-back wrong");

  a_split_stages: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ13
    s_frame_split |=> STAGE_B_CODE_O == $past(GAIN_B_CODE_I))
    else $error("stage b not taken from gain b");

  a_combined_stages: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ14
    s_frame_apply ##0 (mode == spgr_pkg::SPGR_MODE_COMBINED_LINEAR_GAIN_MODE) |=> STAGE_B_CODE_O == STAGE_A_CODE_O)
    else $error("combined mode stages differ");

  a_reset_defaults: assert property (@(posedge CLK_I) !RST_N_I |=> // RQ11
    REG_RDATA_O == 8'h00 && !EXT_BIAS_SEL_O && !STANDBY_O && !INTERNAL_RST_O && gain_a_r == spgr_pkg::GAIN_A_RST
    && STAGE_A_CODE_O == spgr_pkg::GAIN_A_RST && STAGE_B_CODE_O == spgr_pkg::GAIN_B_RST)
    else $error("register defaults wrong after reset");

  a_pwr_readback: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ1
    REG_RD_I && hit(REG_ADDR_I, spgr_pkg::PWR_CFG_OFS) |=> REG_RDATA_O == {4'h0, $past(ext_bias_r), 2'h0, $past(standby_r)})
    else $error("power configuration read-back wrong");

  a_rst_readback: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ10
    REG_RD_I && hit(REG_ADDR_I, spgr_pkg::RST_CTL_OFS) |=> REG_RDATA_O == {3'h0, $past(rst_ctl_r)})
    else $error("reset control read-back wrong");

  a_unmapped_read: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ11
    REG_RD_I && !hit(REG_ADDR_I, spgr_pkg::PWR_CFG_OFS) && !hit(REG_ADDR_I, spgr_pkg::RST_CTL_OFS)
    && !hit(REG_ADDR_I, spgr_pkg::GAIN_A_OFS) |=> REG_RDATA_O == 8'h00)
    else $error("unmapped read not zero");

  a_rdata_holds: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ11
    !REG_RD_I |=> $stable(REG_RDATA_O))
    else $error("read data moved without a read");

  a_rst_write_taken: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ10
    wr_rst |=> rst_ctl_r == $past(REG_WDATA_I[4:0]))
    else $error("reset control write lost");

  a_gain_write_taken: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ11
    wr_gain && !soft_rst |=> gain_a_r == $past(REG_WDATA_I[5:0]))
    else $error("gain a write lost");

  a_mode_keep_stage: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ12
    s_frame_keep |=> $stable(STAGE_A_CODE_O) && $stable(STAGE_B_CODE_O))
    else $error("no-update mode changed stages");

  a_state_rst_keeps: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ8
    STATE_RST_O && !SOFT_RST_O && !REG_WR_I |=> $stable(gain_a_r) && STAGE_A_CODE_O == spgr_pkg::GAIN_A_RST)
    else $error("state reset lost gain a or kept stage");

  a_post_rst_stage: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RQ7
    POST_CONV_RST_O |=> STAGE_B_CODE_O == spgr_pkg::GAIN_B_RST)
    else $error("post converter reset left stage b");

endmodule

`default_nettype wire

// ==== verif/spgr_host_model.sv ====
// host side model issuing register writes and reads on the strobe port
`timescale 1ns/1ps
`default_nettype none
module spgr_host_model (
  input  wire logic       clk_i,
  output var  logic [7:0] addr_o,
  output var  logic [7:0] wdata_o,
  output var  logic       wr_o,
  output var  logic       rd_o,
  input  wire logic [7:0] rdata_i
);
  initial begin
    addr_o  = 8'hA5;
    wdata_o = 8'h5A;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end
  // callers pass only defined bits, except one write of 8'h5A to unmapped 8'h22; unused and factory bits stay zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(negedge clk_i);
    wr_o    = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d; // released lines never keep the last value
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o   = 1'b1;
    @(negedge clk_i);
    rd_o   = 1'b0;
    addr_o = ~a;
    d      = rdata_i;
  endtask
endmodule
`default_nettype wire

// ==== verif/tb_spgr_regs.sv ====
// self-checking bench for the power, reset and gain register bank
`timescale 1ns/1ps
`default_nettype none
module tb_spgr_regs;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] rb; logic [1:0] f;} spgr_row_type;
  logic       CLK_I = 1'b0;
  logic       RST_N_I = 1'b0;
  logic [7:0] addr, wdata, rdata, v;
  logic       wr, rd, bias, sby, fr, po, pt, st, sf, ir;
  logic [1:0] GAIN_MODE_I = 2'b11;
  logic [5:0] GAIN_B_CODE_I = 6'h00;
  logic       FRAME_START_I = 1'b0;
  logic [5:0] sa, sb;
  int         err_total = 0;
  int         checks = 0;
  int         cycles = 0;
  // flags column is {bias, standby}; rows 3..6 are written while in standby
  spgr_row_type rows [8] = '{'{8'h0C, 8'h09, 8'h09, 2'b11}, '{8'h0C, 8'h08, 8'h08, 2'b10},
    '{8'h0C, 8'h01, 8'h01, 2'b01}, '{8'h10, 8'h3F, 8'h3F, 2'b01}, '{8'h10, 8'h00, 8'h00, 2'b01},
    '{8'h22, 8'h5A, 8'h00, 2'b01}, '{8'h0E, 8'h1F, 8'h1F, 2'b00}, '{8'h0E, 8'h00, 8'h00, 2'b00}};
  always #5 CLK_I = ~CLK_I;
  spgr_host_model u_spgr_host_model (.clk_i(CLK_I), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
    .rdata_i(rdata));
  spgr_regs u_spgr_regs (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .GAIN_MODE_I(GAIN_MODE_I),
    .GAIN_B_CODE_I(GAIN_B_CODE_I), .FRAME_START_I(FRAME_START_I), .EXT_BIAS_SEL_O(bias), .STANDBY_O(sby),
    .FRONT_CONV_RST_O(fr), .POST_CONV_RST_O(po), .SENSOR_PORT_RST_O(pt), .STATE_RST_O(st),
    .SOFT_RST_O(sf), .INTERNAL_RST_O(ir), .STAGE_A_CODE_O(sa), .STAGE_B_CODE_O(sb));
  task automatic tally_and_finish;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    u_spgr_host_model.rd(a, v);
    chk("readback", e, v);
  endtask
  task automatic frame(input logic [1:0] m, input logic [5:0] b, input logic [5:0] ea, input logic [5:0] eb);
    @(negedge CLK_I);
    GAIN_MODE_I   = m;
    GAIN_B_CODE_I = b;
    FRAME_START_I = 1'b1;
    @(negedge CLK_I);
    FRAME_START_I = 1'b0;
    chk("stages", {ea[3:0], eb[3:0]}, {sa[3:0], sb[3:0]});
    chk("stage_hi", {2'b00, ea[5:4], 2'b00, eb[5:4]}, {2'b00, sa[5:4], 2'b00, sb[5:4]});
  endtask
  always @(posedge CLK_I) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (10) @(negedge CLK_I);
    RST_N_I = 1'b1;
    rdchk(8'h0C, 8'h00);
    rdchk(8'h0E, 8'h00);
    rdchk(8'h10, 8'h0E);
    chk("stage_a", 8'h0E, {2'b00, sa});
    foreach (rows[i]) begin
      u_spgr_host_model.wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].rb);
      chk("bias_sby", {6'h00, rows[i].f}, {6'h00, bias, sby});
    end
    u_spgr_host_model.wr(8'h0C, 8'h01);
    u_spgr_host_model.wr(8'h10, 8'h14);
    frame(2'b10, 6'h05, 6'h0E, 6'h0E);
    u_spgr_host_model.wr(8'h0C, 8'h00);
    frame(2'b10, 6'h05, 6'h14, 6'h14);
    frame(2'b00, 6'h05, 6'h14, 6'h05);
    frame(2'b01, 6'h07, 6'h14, 6'h07);
    frame(2'b11, 6'h09, 6'h14, 6'h07);
    for (int i = 1; i < 5; i++) begin
      frame(2'b00, 6'h05, 6'h14, 6'h05);
      u_spgr_host_model.wr(8'h0E, 8'(1 << i));
      rdchk(8'h10, 8'h14);
      chk("rst_outs", {2'b00, 5'(1 << i), 1'b1}, {2'b00, fr, po, pt, st, sf, ir});
      chk("stage_a", 8'h0E, {2'b00, sa});
      chk("stage_b", 8'h0E, {2'b00, sb});
      u_spgr_host_model.wr(8'h0E, 8'h00);
      chk("int_rst", 8'h00, {7'h00, ir});
    end
    u_spgr_host_model.wr(8'h0C, 8'h09);
    u_spgr_host_model.wr(8'h0E, 8'h01);
    chk("rst_outs", 8'h03, {2'b00, fr, po, pt, st, sf, ir});
    rdchk(8'h10, 8'h0E);
    rdchk(8'h0C, 8'h00);
    u_spgr_host_model.wr(8'h0E, 8'h00);
    u_spgr_host_model.wr(8'h10, 8'h3F);
    frame(2'b00, 6'h05, 6'h3F, 6'h05);
    frame(2'b00, 6'h0A, 6'h3F, 6'h0A);
    u_spgr_host_model.wr(8'h0C, 8'h09);
    RST_N_I = 1'b0;
    repeat (2) @(negedge CLK_I);
    RST_N_I = 1'b1;
    rdchk(8'h10, 8'h0E);
    rdchk(8'h0C, 8'h00);
    chk("bias_sby", 8'h00, {6'h00, bias, sby});
    chk("stage_a", 8'h0E, {2'b00, sa});
    chk("stage_b", 8'h0E, {2'b00, sb});
    tally_and_finish();
  end
endmodule
`default_nettype wire
